// File: gpc_pkg.sv
/*
  Package for the general-purpose pin port: register map, command codes,
  field positions and reset values.
  Assumes a single 50 MHz system clock and a plain strobe register port.
*/
package gpc_pkg;
  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int GPC_NPINS = 24;
  localparam int GPC_IDX_W = 5;
  localparam int GPC_AN_FIRST = 16;
  localparam int GPC_NAN = 8;
  localparam int GPC_ADDR_W = 8;
  localparam int GPC_DATA_W = 32;
  localparam int GPC_LOCAL_PORT = 0;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] GPC_SAMPLE_OFS = 8'h00;
  localparam logic [7:0] GPC_WAY_OFS = 8'h04;
  localparam logic [7:0] GPC_RECV_OFS = 8'h08;
  localparam logic [7:0] GPC_DRV_OFS = 8'h0c;
  localparam logic [7:0] GPC_BIDIR_OFS = 8'h10;
  localparam logic [7:0] GPC_ZERO_OFS = 8'h14;
  localparam logic [7:0] GPC_ONE_OFS = 8'h18;
  localparam logic [7:0] GPC_VALUE_OFS = 8'h1c;
  localparam logic [7:0] GPC_DIRALL_OFS = 8'h20;
  localparam logic [7:0] GPC_OUTALL_OFS = 8'h24;
  localparam logic [7:0] GPC_ANALOG_OFS = 8'h28;
  localparam logic [7:0] GPC_LEVALL_OFS = 8'h2c;

  // ----------------------------------------------------------------------
  // Write-data fields for per-pin commands
  // ----------------------------------------------------------------------
  localparam int GPC_PIN_LSB = 0;
  localparam int GPC_PORT_LSB = 8;
  localparam int GPC_PORT_W = 3;
  localparam int GPC_ARG_LSB = 16;

  // ----------------------------------------------------------------------
  // Reset values and read answers
  // ----------------------------------------------------------------------
  localparam logic [23:0] GPC_WAY_RST = 24'h000000;
  localparam logic [23:0] GPC_OUT_RST = 24'h000000;
  localparam logic [7:0] GPC_ANALOG_RST = 8'hff;
  localparam logic [31:0] GPC_TRUE_WORD = 32'hffffffff;
  localparam logic [31:0] GPC_FALSE_WORD = 32'h00000000;

  typedef enum logic [3:0] {
    GPC_CMD_NONE = 4'h0,
    GPC_CMD_RECV = 4'h1,
    GPC_CMD_DRIVE = 4'h2,
    GPC_CMD_BIDIR = 4'h3,
    GPC_CMD_ZERO = 4'h4,
    GPC_CMD_ONE = 4'h5,
    GPC_CMD_VALUE = 4'h6,
    GPC_CMD_WAY = 4'h7
  } gpc_cmd_type;
endpackage

// File: gpc_sync.sv
/*
  Two-flop synchroniser for the pad input levels.
  Assumes the pads are asynchronous to sys_clk_i.
*/
`timescale 1ns/100ps
module gpc_sync
  import gpc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [GPC_NPINS-1:0] async_i,
  output logic [GPC_NPINS-1:0] sync_o
);
  logic [GPC_NPINS-1:0] meta;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule // gpc_sync

// File: gpc_pin_cell.sv
/*
  One pin's direction, output value and analog-mode state.
  Assumes the command decode is done by the port; set_way_i and set_out_i can both arrive high.
*/
`timescale 1ns/100ps
module gpc_pin_cell #(
  parameter bit ANALOG_SHARED = 1'b0
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic set_way_i,
  input wire logic way_val_i,
  input wire logic set_out_i,
  input wire logic out_val_i,
  output logic way_o,
  output logic out_o,
  output logic analog_o
);
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      way_o <= 1'b0;
      out_o <= 1'b0;
      analog_o <= ANALOG_SHARED;
    end else begin
      if (set_way_i) begin
        way_o <= way_val_i;
        analog_o <= 1'b0;
      end
      if (set_out_i) begin
        out_o <= out_val_i;
      end
    end
  end
endmodule // gpc_pin_cell

// File: gpc_port.sv
/*
  General-purpose pin port: 24 pins, each with a direction bit and a
  stored output value, reached over a strobe register port.
  Assumes a single clock, synchronous strobes from the bus master, and
  pads that resolve the pin from pin_o and pin_oe_o outside.
*/
// The plain strobed port and the address map were chosen for this implementation.
// Summary of operation
// - Level read returns all ones for a high pin, zero for low.
// - Level read never changes the pin's direction.
// - Twenty-four pins from zero; pins 16 to 23 share analog pads.
// - Analog-shared pins start analog; any direction set makes them digital.
// - Once digital, an analog-shared pin stays digital until reset.
// - After reset every pin is an input with its driver off.
// - Receive command clears the selected pin's direction to input.
// - A pin made input has its driver released to high impedance.
// - Drive command makes the pin an output showing its stored value.
// - Bidirectional read returns the pin's level and makes it input at the same edge.
// - Bidirectional write makes the pin output; zero low, nonzero high.
// - Drive-zero loads a low output value and makes the pin output.
// - Value write changes the stored value only, not the direction.
// - Pin index selects bit n of port zero; writes to other ports are ignored.
// - Direction bit one means output, zero means input; it is readable.
// - Drive-one loads a high output value and makes the pin output.
`timescale 1ns/100ps
module gpc_port
  import gpc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [GPC_ADDR_W-1:0] addr_i,
  input wire logic [GPC_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [GPC_DATA_W-1:0] rdata_o,
  input wire logic [GPC_NPINS-1:0] pin_i,
  output logic [GPC_NPINS-1:0] pin_o,
  output logic [GPC_NPINS-1:0] pin_oe_o,
  output logic [GPC_NAN-1:0] analog_mode_o
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] gpc_bool_word(input logic b);
    gpc_bool_word = b ? GPC_TRUE_WORD : GPC_FALSE_WORD;
  endfunction

  // Decodes a register offset into the per-pin command it carries
  function automatic gpc_cmd_type gpc_decode(input logic [7:0] a);
    case (a)
      GPC_RECV_OFS: gpc_decode = GPC_CMD_RECV;
      GPC_DRV_OFS: gpc_decode = GPC_CMD_DRIVE;
      GPC_BIDIR_OFS: gpc_decode = GPC_CMD_BIDIR;
      GPC_ZERO_OFS: gpc_decode = GPC_CMD_ZERO;
      GPC_ONE_OFS: gpc_decode = GPC_CMD_ONE;
      GPC_VALUE_OFS: gpc_decode = GPC_CMD_VALUE;
      GPC_WAY_OFS: gpc_decode = GPC_CMD_WAY;
      default: gpc_decode = GPC_CMD_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Pad input synchroniser
  // ----------------------------------------------------------------------
  logic [GPC_NPINS-1:0] level;

  gpc_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .async_i(pin_i),
    .sync_o(level)
  );

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  wire [GPC_IDX_W-1:0] sel_pin = wdata_i[GPC_PIN_LSB +: GPC_IDX_W];
  wire [GPC_PORT_W-1:0] sel_port = wdata_i[GPC_PORT_LSB +: GPC_PORT_W];
  wire arg_bit = wdata_i[GPC_ARG_LSB];
  // Writes carry pin, port and argument in wdata; reads carry the pin
  // index in the low field of the last write to the sample register, so the
  // read index comes from a latched selector below.
  wire pin_ok = (sel_pin < GPC_IDX_W'(GPC_NPINS));
  wire port_ok = (sel_port == GPC_PORT_W'(GPC_LOCAL_PORT));
  wire gpc_cmd_type wr_cmd = gpc_decode(addr_i);
  wire gpc_cmd_type rd_cmd = gpc_decode(addr_i);
  wire wr_hit = wr_i && pin_ok && port_ok;
  wire wr_all_dir = wr_i && (addr_i == GPC_DIRALL_OFS);
  wire wr_all_out = wr_i && (addr_i == GPC_OUTALL_OFS);

  // Read index: software writes the index to the sample register first;
  // a read then addresses that pin. Keeps reads single-cycle.
  logic [GPC_IDX_W-1:0] rd_pin;
  wire idx_wr = wr_i && (addr_i == GPC_SAMPLE_OFS) && pin_ok && port_ok;
  wire rd_bidir = rd_i && (rd_cmd == GPC_CMD_BIDIR);

  // ----------------------------------------------------------------------
  // Per-pin cells
  // ----------------------------------------------------------------------
  logic [GPC_NPINS-1:0] way;
  logic [GPC_NPINS-1:0] outv;
  logic [GPC_NPINS-1:0] analog;
  logic [GPC_NPINS-1:0] set_way;
  logic [GPC_NPINS-1:0] way_val;
  logic [GPC_NPINS-1:0] set_out;
  logic [GPC_NPINS-1:0] out_val;

  genvar g;
  generate
    for (g = 0; g < GPC_NPINS; g++) begin : g_pin
      wire hit = wr_hit && (sel_pin == GPC_IDX_W'(g));
      wire rd_here = rd_bidir && (rd_pin == GPC_IDX_W'(g));
      wire w_recv = hit && (wr_cmd == GPC_CMD_RECV);
      wire w_drv = hit && (wr_cmd == GPC_CMD_DRIVE);
      wire w_bidir = hit && (wr_cmd == GPC_CMD_BIDIR);
      wire w_zero = hit && (wr_cmd == GPC_CMD_ZERO);
      wire w_one = hit && (wr_cmd == GPC_CMD_ONE);
      wire w_val = hit && (wr_cmd == GPC_CMD_VALUE);
      wire w_way = hit && (wr_cmd == GPC_CMD_WAY);
      wire w_arg = (wdata_i[GPC_ARG_LSB +: 16] != 16'h0000);
      assign set_way[g] = w_recv || w_drv || w_bidir || w_zero || w_one ||
                          w_way || rd_here || wr_all_dir;
      assign way_val[g] = wr_all_dir ? wdata_i[g] :
                          (w_drv || w_bidir || w_zero || w_one ||
                           (w_way && arg_bit));
      assign set_out[g] = w_bidir || w_zero || w_one || w_val || wr_all_out;
      assign out_val[g] = wr_all_out ? wdata_i[g] :
                          (w_one || ((w_bidir || w_val) && w_arg));

      gpc_pin_cell #(
        .ANALOG_SHARED(g >= GPC_AN_FIRST)
      ) u_cell (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .set_way_i(set_way[g]),
        .way_val_i(way_val[g]),
        .set_out_i(set_out[g]),
        .out_val_i(out_val[g]),
        .way_o(way[g]),
        .out_o(outv[g]),
        .analog_o(analog[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  wire sel_level = level[rd_pin];
  logic [GPC_DATA_W-1:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    if (rd_i) begin
      case (addr_i)
        GPC_SAMPLE_OFS: next_rdata = gpc_bool_word(sel_level);
        GPC_BIDIR_OFS: next_rdata = gpc_bool_word(sel_level);
        GPC_WAY_OFS: next_rdata = {31'h0, way[rd_pin]};
        GPC_VALUE_OFS: next_rdata = gpc_bool_word(outv[rd_pin]);
        GPC_DIRALL_OFS: next_rdata = {8'h00, way};
        GPC_OUTALL_OFS: next_rdata = {8'h00, outv};
        GPC_ANALOG_OFS: next_rdata = {24'h0, analog[GPC_NPINS-1:GPC_AN_FIRST]};
        GPC_LEVALL_OFS: next_rdata = {8'h00, level};
        default: next_rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  logic [GPC_NPINS-1:0] digital_way;
  assign digital_way = way & ~analog;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_pin <= '0;
      rdata_o <= '0;
      pin_o <= GPC_OUT_RST;
      pin_oe_o <= GPC_WAY_RST;
      analog_mode_o <= GPC_ANALOG_RST;
    end else begin
      if (idx_wr) begin
        rd_pin <= sel_pin;
      end
      rdata_o <= next_rdata;
      pin_o <= outv;
      pin_oe_o <= digital_way;
      analog_mode_o <= analog[GPC_NPINS-1:GPC_AN_FIRST];
    end
  end
endmodule // gpc_port

// File: gpc_port_properties.sv
/*
  Concurrent checks on the pin port, bound to gpc_port.
  Assumes a single clock and the strobe bus of the package.
*/
`timescale 1ns/100ps
module gpc_port_chk
  import gpc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [GPC_ADDR_W-1:0] addr_i,
  input wire logic [GPC_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [GPC_DATA_W-1:0] rdata_o,
  input wire logic [GPC_NPINS-1:0] pin_i,
  input wire logic [GPC_NPINS-1:0] pin_o,
  input wire logic [GPC_NPINS-1:0] pin_oe_o,
  input wire logic [GPC_NAN-1:0] analog_mode_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  wire pw = wr_i && wdata_i[10:8] == 3'h0 && wdata_i[4:0] < 5'd24;
  wire rd_lvl = rd_i && addr_i == GPC_SAMPLE_OFS;
  wire rd_bid = rd_i && addr_i == GPC_BIDIR_OFS;
  property p_cmd(ofs, v);
    int p;
    (pw && addr_i == ofs, p = wdata_i[4:0])
      |-> ##2 pin_oe_o[p] && pin_o[p] == v;
  endproperty
  property p_recv;
    int p;
    (pw && addr_i == GPC_RECV_OFS, p = wdata_i[4:0]) |-> ##2 !pin_oe_o[p];
  endproperty
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_drive_one: assert property (p_cmd(GPC_ONE_OFS, 1'b1))
    else $error("drive one not seen on pin");
  a_drive_zero: assert property (p_cmd(GPC_ZERO_OFS, 1'b0))
    else $error("drive zero not seen on pin");
  a_recv_release: assert property (p_recv)
    else $error("driver still on after receive");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == '0)
    else $error("read data outside read slot");
  a_level_word: assert property ($past(rd_lvl) |->
    rdata_o == GPC_TRUE_WORD || rdata_o == GPC_FALSE_WORD)
    else $error("level read not all ones or zero");
  a_oe_has_cause: assert property ($changed(pin_oe_o) |->
    $past(wr_i, 2) || $past(rd_bid) || $past(rd_bid, 2))
    else $error("direction changed without a command");
  a_analog_sticky: assert property (
    (analog_mode_o & ~$past(analog_mode_o)) == '0)
    else $error("pin went back to analog");
  a_analog_off: assert property (
    (pin_oe_o[GPC_NPINS-1:GPC_AN_FIRST] & analog_mode_o) == '0)
    else $error("analog pin driven");
  a_reset_idle: assert property ($rose(nrst_i) |->
    pin_oe_o == '0 && analog_mode_o == GPC_ANALOG_RST)
    else $error("bad state after reset");
  c_bidir_wr: cover property (pw && addr_i == GPC_BIDIR_OFS);
  c_bidir_rd: cover property (rd_bid);
  c_level_rd: cover property (rd_lvl);
endmodule // gpc_port_chk

bind gpc_port gpc_port_chk chk (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
  .analog_mode_o(analog_mode_o));

// File: gpc_pads.sv
/*
  Model of the devices wired to the pins.
  Assumes the bench sets their levels and enables.
*/
`timescale 1ns/100ps
module gpc_pads
  import gpc_pkg::*;
(
  input wire logic [GPC_NPINS-1:0] pin_o,
  input wire logic [GPC_NPINS-1:0] pin_oe_o,
  input wire logic [GPC_NPINS-1:0] ext_lvl_i,
  input wire logic [GPC_NPINS-1:0] ext_en_i,
  output logic [GPC_NPINS-1:0] pad_o
);
  // Released pads float up through board pull-ups
  assign pad_o = (pin_oe_o & pin_o) | (~pin_oe_o & ~ext_en_i) |
    (~pin_oe_o & ext_en_i & ext_lvl_i);
endmodule // gpc_pads

// File: tb_top.sv
/*
  Self-checking bench for gpc_port.
  Assumes gpc_pads models the far side of the pins.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
  import gpc_pkg::*;
  logic sys_clk_i, nrst_i, wr_i, rd_i;
  logic [GPC_ADDR_W-1:0] addr_i;
  logic [GPC_DATA_W-1:0] wdata_i, rdata_o, d;
  logic [GPC_NPINS-1:0] pad, pin_o, pin_oe_o, ext_lvl, ext_en, b;
  logic [GPC_NAN-1:0] analog_mode_o;
  int miscompares = 0;
  int checks_done = 0;
  gpc_port dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pin_i(pad), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .analog_mode_o(analog_mode_o));
  gpc_pads pads (.pin_o(pin_o), .pin_oe_o(pin_oe_o), .ext_lvl_i(ext_lvl),
    .ext_en_i(ext_en), .pad_o(pad));
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] cw(input logic [4:0] p,
    input logic [15:0] g = 16'h0, input logic [2:0] pt = 3'h0);
    return {g, 5'h0, pt, 3'h0, p};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // Output flops sit one edge behind the taking edge
  task automatic settle;
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic do_reset;
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    settle;
    `CHK("oe", 24'h0, pin_oe_o)
    `CHK("out", 24'h0, pin_o)
    `CHK("analog", 8'hff, analog_mode_o)
    $display("done reset");
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_drive;
    wr(GPC_ONE_OFS, cw(5));
    settle;
    `CHK("one", 2'b11, {pin_oe_o[5], pin_o[5]})
    wr(GPC_ZERO_OFS, cw(5));
    settle;
    `CHK("zero", 2'b10, {pin_oe_o[5], pin_o[5]})
    wr(GPC_RECV_OFS, cw(5));
    settle;
    `CHK("recv", 1'b0, pin_oe_o[5])
    `CHK("pad", 1'b1, pad[5])
    wr(GPC_VALUE_OFS, cw(3, 16'h1));
    settle;
    `CHK("value", 2'b01, {pin_oe_o[3], pin_o[3]})
    wr(GPC_SAMPLE_OFS, cw(3));
    rd(GPC_VALUE_OFS);
    `CHK("value rd", GPC_TRUE_WORD, d)
    wr(GPC_DRV_OFS, cw(3));
    settle;
    `CHK("driver", 2'b11, {pin_oe_o[3], pad[3]})
    $display("done drive");
  endtask
  task automatic t_level;
    @(posedge sys_clk_i);
    ext_en[7] <= 1'b1;
    ext_lvl[7] <= 1'b1;
    wr(GPC_SAMPLE_OFS, cw(7));
    settle;
    rd(GPC_SAMPLE_OFS);
    `CHK("lvl hi", GPC_TRUE_WORD, d)
    @(posedge sys_clk_i);
    ext_lvl[7] <= 1'b0;
    settle;
    rd(GPC_SAMPLE_OFS);
    `CHK("lvl lo", GPC_FALSE_WORD, d)
    wr(GPC_SAMPLE_OFS, cw(3));
    rd(GPC_SAMPLE_OFS);
    `CHK("lvl own", GPC_TRUE_WORD, d)
    settle;
    `CHK("lvl way", 2'b01, {pin_oe_o[7], pin_oe_o[3]})
    $display("done level");
  endtask
  task automatic t_analog;
    wr(GPC_BIDIR_OFS, cw(20, 16'h5));
    settle;
    `CHK("bid wr", 3'b011, {analog_mode_o[4], pin_oe_o[20], pin_o[20]})
    @(posedge sys_clk_i);
    ext_en[20] <= 1'b1;
    ext_lvl[20] <= 1'b1;
    wr(GPC_SAMPLE_OFS, cw(20));
    rd(GPC_BIDIR_OFS);
    `CHK("bid rd", GPC_TRUE_WORD, d)
    @(posedge sys_clk_i);
    ext_lvl[20] <= 1'b0;
    settle;
    `CHK("bid in", 1'b0, pin_oe_o[20])
    rd(GPC_BIDIR_OFS);
    `CHK("bid lo", GPC_FALSE_WORD, d)
    wr(GPC_BIDIR_OFS, cw(20));
    settle;
    `CHK("bid 0", 3'b010, {analog_mode_o[4], pin_oe_o[20], pin_o[20]})
    wr(GPC_WAY_OFS, cw(17, 16'h1));
    settle;
    `CHK("way", 9'h1ed, {pin_oe_o[17], analog_mode_o})
    wr(GPC_SAMPLE_OFS, cw(17));
    rd(GPC_WAY_OFS);
    `CHK("way rd", 32'h00000001, d)
    $display("done analog");
  endtask
  task automatic t_refuse;
    b = pin_oe_o;
    wr(GPC_ONE_OFS, cw(6, 16'h0, 3'h1));
    wr(GPC_ONE_OFS, cw(5'd24));
    settle;
    `CHK("port1", b, pin_oe_o)
    rd(8'hfc);
    `CHK("unmapped", 32'h0, d)
    $display("done refuse");
  endtask
  // Whole-port writes and reads; all-direction write ends analog mode
  task automatic t_bulk;
    rd(GPC_ANALOG_OFS);
    `CHK("an rd", 32'h000000ed, d)
    wr(GPC_OUTALL_OFS, 32'h0000a50f);
    wr(GPC_DIRALL_OFS, 32'h000f00ff);
    settle;
    `CHK("all oe", 24'h0f00ff, pin_oe_o)
    `CHK("all out", 24'h00a50f, pin_o)
    `CHK("all an", 8'h00, analog_mode_o)
    rd(GPC_DIRALL_OFS);
    `CHK("dir rd", 32'h000f00ff, d)
    rd(GPC_OUTALL_OFS);
    `CHK("out rd", 32'h0000a50f, d)
    rd(GPC_LEVALL_OFS);
    `CHK("lvl all", 32'h00e0ff0f, d)
    $display("done bulk");
  endtask
  task automatic end_sim;
    $display("checks %0d bad %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    miscompares++;
    end_sim;
  end
  initial begin
    {nrst_i, wr_i, rd_i, addr_i, wdata_i} = '0;
    {ext_lvl, ext_en} = '0;
    do_reset;
    t_drive;
    t_level;
    t_analog;
    t_refuse;
    t_bulk;
    do_reset;
    end_sim;
  end
endmodule // tb_top
